// file: dv/clp_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module clp_ctrl_bench;
  localparam logic [6:0][40:0] SC = {41'd30, 41'd26, 41'd22, 41'd18, 41'd14, 41'd10, 41'd6};
  localparam logic [3:0][40:0] WC = {41'd9, 41'd7, 41'd5, 41'd3};
  localparam logic [7:0] IDX [6] = '{8'h6b, 8'h6c, 8'h6e, 8'h70, 8'h71, 8'h6d};
  localparam logic [7:0] RV [6] = '{8'h00, 8'h01, 8'h88, 8'h00, 8'h00, 8'h00};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  clp_pkg::clp_wb_req_s req = '0;
  logic ack, pin, cs, slp, irq, ep, cd;
  logic [31:0] dat, r;
  logic bg = 1'b0, fg = 1'b0, stp = 1'b0, alm = 1'b0, tl = 1'b0;
  logic [3:0] dd = 4'h2;
  logic [1:0] s;
  int n_fail = 0, compares = 0, cyc = 0;
  clp_ctrl #(.SLEEP_CYC(SC), .WAKE_CYC(WC)) i_clp_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
    .wb_req(req), .wb_ack(ack), .wb_dat_o(dat), .background_cal_enable(bg),
    .foreground_done_flag(fg), .cal_stopped_flag(stp), .alarm_flag(alm), .cal_done(cd),
    .cal_start(cs), .core_sleep(slp), .external_trigger_pin(ep), .status_output_pin(pin),
    .irq(irq));
  clp_host_model i_clp_host_model (.clk_sys(clk_sys), .rst_n(rst_n), .trig_lvl(tl),
    .done_dly(dd), .cal_start(cs), .external_trigger_pin(ep), .cal_done(cd));
  // Free running clock.
  initial
    forever #25 clk_sys = ~clk_sys;
  // Verdict and end of run.
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // A hang would otherwise stall the run forever.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Classic cycle: held until ack is sampled high, then released.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
    output logic [31:0] rd);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b1, w, 4'hf, {idx, 2'b00}, {24'h0, d}};
    @(posedge clk_sys);
    while (ack !== 1'b1)
      @(posedge clk_sys);
    rd = dat;
    req <= '0;
  endtask : bus
  function automatic logic exp_pin(input logic [1:0] q, input logic f, t, a);
    return q == 2'd0 ? f : q == 2'd1 ? t : q == 2'd2 ? a : 1'b0;
  endfunction : exp_pin
  // One autonomous round: measure sleep, then settling up to the start pulse.
  task automatic run_lp(input int sc, input int wc);
    int n;
    bus(1'b1, 8'h6e, 8'h00, r);
    bus(1'b1, 8'h6e, {sc[2:0], wc[1:0], 3'b001}, r);
    while (slp !== 1'b1)
      @(negedge clk_sys);
    n = 0;
    while (slp === 1'b1)
    begin
      n++;
      @(negedge clk_sys);
    end
    chk(n, 32'(SC[sc]), "sleep length");
    n = 0;
    while (cs !== 1'b1)
    begin
      n++;
      @(negedge clk_sys);
    end
    chk(n, 32'(WC[wc]), "wake length");
  endtask : run_lp
  // Main sequence.
  initial
  begin
    void'($urandom(32'h733e));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (IDX[i])
    begin
      bus(1'b0, IDX[i], 8'h00, r);
      chk(r, {24'h0, RV[i]}, "reset value");
    end
    $display("test reset done");
    repeat (12)
    begin
      s = 2'($urandom);
      tl <= 1'($urandom);
      bus(1'b1, 8'h6c, {7'h0, s[1]}, r);
      bus(1'b1, 8'h6b, {7'h0, s[0]}, r);
      repeat (4) @(posedge clk_sys);
      bus(1'b0, 8'h72, 8'h00, r);
      chk(r[3], s[0] ? tl : s[1], "trigger source");
    end
    $display("test trigger source done");
    for (int k = 0; k < 16; k++)
    begin
      s = k[1:0];
      bus(1'b1, 8'h6b, {5'h0, s, 1'b0}, r);
      fg <= 1'($urandom);
      stp <= 1'($urandom);
      alm <= 1'($urandom);
      repeat (3) @(posedge clk_sys);
      chk(pin, exp_pin(s, fg, stp, alm), "status pin");
    end
    $display("test status pin done");
    fg <= 1'b0;
    stp <= 1'b0;
    bus(1'b1, 8'h70, 8'h07, r);
    bus(1'b1, 8'h71, 8'h00, r);
    fg <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b0, "masked irq");
    bus(1'b1, 8'h71, 8'h01, r);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1, "irq raised");
    bus(1'b1, 8'h70, 8'h01, r);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0, "irq cleared");
    $display("test interrupt done");
    bus(1'b1, 8'h6c, 8'h01, r);
    bus(1'b1, 8'h6e, 8'h89, r);
    repeat (10) @(posedge clk_sys);
    chk(slp, 1'b0, "no sleep without background");
    bg <= 1'b1;
    for (int k = 0; k < 7; k++)
      run_lp(k, (k + 1) % 4);
    // At least one start pulse of the rounds above must have left the sticky wake event behind.
    bus(1'b0, 8'h70, 8'h00, r);
    chk(r[2], 1'b1, "wake event sticky");
    $display("test autonomous done");
    bus(1'b1, 8'h6e, 8'h00, r);
    bus(1'b1, 8'h6e, 8'h8b, r);
    repeat (60) @(posedge clk_sys);
    chk(slp, 1'b1, "sleep while trigger high");
    bus(1'b1, 8'h6c, 8'h00, r);
    repeat (4) @(posedge clk_sys);
    chk(slp, 1'b0, "wake on trigger low");
    $display("test trigger mode done");
    summarize();
  end
endmodule : clp_ctrl_bench
`default_nettype wire

// file: dv/clp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module clp_host_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bench commands.
  input wire logic trig_lvl,
  input wire logic [3:0] done_dly,
  // Device side.
  input wire logic cal_start,
  output logic external_trigger_pin,
  output logic cal_done
);
  logic [3:0] cnt_q;
  logic busy_q;
  // Pin follows the host level; done comes done_dly+1 cycles after a start, so slow engines show.
  always_ff @(posedge clk_sys)
  begin
    external_trigger_pin <= trig_lvl;
    cal_done <= 1'b0;
    if (!rst_n)
      busy_q <= 1'b0;
    else if (cal_start)
    begin
      busy_q <= 1'b1;
      cnt_q <= done_dly;
    end
    else if (busy_q && cnt_q == 4'h0)
    begin
      busy_q <= 1'b0;
      cal_done <= 1'b1;
    end
    else
      cnt_q <= cnt_q - 4'h1;
  end
endmodule : clp_host_model
`default_nettype wire

// file: rtl/clp_ctrl.sv
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module clp_ctrl #(
  parameter logic [6:0][40:0] SLEEP_CYC = clp_pkg::SLEEP_CYC,
  parameter logic [3:0][40:0] WAKE_CYC = clp_pkg::WAKE_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Wishbone slave.
  input wire clp_pkg::clp_wb_req_s wb_req,
  output logic wb_ack,
  output logic [31:0] wb_dat_o,
  // Calibration engine status and handshake.
  input wire logic background_cal_enable,
  input wire logic foreground_done_flag,
  input wire logic cal_stopped_flag,
  input wire logic alarm_flag,
  input wire logic cal_done,
  output logic cal_start,
  output logic core_sleep,
  // Pins.
  input wire logic external_trigger_pin,
  output logic status_output_pin,
  // Interrupt.
  output logic irq
);
  clp_pkg::clp_state_s q;
  clp_pkg::clp_state_s d;
  logic hit;
  logic wr;
  logic [7:0] idx;
  logic [7:0] rd;
  logic [7:0] wdat;
  logic trig;
  logic active;
  logic trig_mode;
  logic [2:0] sleep_code;
  logic [1:0] wake_code;
  logic [2:0] ev;

  // Decoded views of the bus request and the stored configuration.
  assign idx = wb_req.adr[9:2];
  assign wdat = wb_req.dat[7:0];
  assign hit = wb_req.cyc & wb_req.stb & ~q.ack;
  assign wr = hit & wb_req.we & wb_req.sel[0];
  assign active = q.lp_cfg[clp_pkg::POS_LOWPOWER_CAL_ENABLE] & background_cal_enable;
  assign trig_mode = q.lp_cfg[clp_pkg::POS_LOWPOWER_TRIGGER_MODE];
  assign wake_code = q.lp_cfg[clp_pkg::POS_WAKE +: 2];
  // Code 7 has no documented length, so it is treated as the longest one.
  assign sleep_code = (q.lp_cfg[clp_pkg::POS_SLEEP +: 3] == 3'h7) ? 3'h6
                      : q.lp_cfg[clp_pkg::POS_SLEEP +: 3];

  // Trigger source: the unselected source has no influence at all.
  assign trig = q.pin_cfg[clp_pkg::POS_TRIG_SRC] ? q.sync[1]
                : q.soft_trig[clp_pkg::POS_SOFT_TRIG];

  // Read multiplexer; unmapped addresses read as zero and are still acked.
  always_comb
  begin
    rd = 8'h00;
    if (wb_req.adr[1:0] != 2'h0)
    begin
      rd = 8'h00;
    end
    else if (idx == clp_pkg::IDX_PIN_CFG)
    begin
      rd = q.pin_cfg;
    end
    else if (idx == clp_pkg::IDX_SOFT_TRIG)
    begin
      rd = q.soft_trig;
    end
    else if (idx == clp_pkg::IDX_LP_CFG)
    begin
      rd = q.lp_cfg;
    end
    else if (idx == clp_pkg::IDX_IRQ_STAT)
    begin
      rd = {5'h00, q.irq_stat};
    end
    else if (idx == clp_pkg::IDX_IRQ_MASK)
    begin
      rd = {5'h00, q.irq_mask};
    end
    else if (idx == clp_pkg::IDX_STATE)
    begin
      rd = {4'h0, trig, q.st};
    end
  end

  // Next state of the whole block.
  always_comb
  begin
    d = q;
    d.sync = {q.sync[0], external_trigger_pin};
    d.ack = hit;
    d.cal_start = 1'b0;
    d.fg_prev = foreground_done_flag;
    d.stop_prev = cal_stopped_flag;
    if (hit)
    begin
      d.rdat = rd;
    end
    // Reserved bits of the pin, trigger and low-power registers are stored as written; keeping them at reset values is software's job.
    if (wr && wb_req.adr[1:0] == 2'h0)
    begin
      if (idx == clp_pkg::IDX_PIN_CFG)
      begin
        d.pin_cfg = wdat;
      end
      else if (idx == clp_pkg::IDX_SOFT_TRIG)
      begin
        d.soft_trig = wdat;
      end
      else if (idx == clp_pkg::IDX_LP_CFG)
      begin
        d.lp_cfg = wdat;
      end
      else if (idx == clp_pkg::IDX_IRQ_MASK)
      begin
        d.irq_mask = wdat[2:0];
      end
    end
    // Sleep and wake sequencer of the offline core.
    case (q.st)
      clp_pkg::ST_OFF:
      begin
        d.st = clp_pkg::ST_SLEEP;
        d.cnt = SLEEP_CYC[sleep_code] - 41'h1;
      end
      clp_pkg::ST_SLEEP:
      begin
        if (trig_mode ? !trig : (q.cnt == 41'h0))
        begin
          d.st = clp_pkg::ST_WAKE;
          d.cnt = WAKE_CYC[wake_code] - 41'h1;
        end
        else
        begin
          d.cnt = (q.cnt == 41'h0) ? q.cnt : q.cnt - 41'h1;
        end
      end
      clp_pkg::ST_WAKE:
      begin
        if (q.cnt == 41'h0)
        begin
          d.st = clp_pkg::ST_CAL;
          d.cal_start = 1'b1;
        end
        else
        begin
          d.cnt = q.cnt - 41'h1;
        end
      end
      clp_pkg::ST_CAL:
      begin
        if (cal_done)
        begin
          d.st = trig_mode ? clp_pkg::ST_PARK : clp_pkg::ST_SLEEP;
          d.cnt = SLEEP_CYC[sleep_code] - 41'h1;
        end
      end
      clp_pkg::ST_PARK:
      begin
        // The core stays awake until the trigger is high again.
        if (trig)
        begin
          d.st = clp_pkg::ST_SLEEP;
        end
      end
      default:
      begin
        d.st = clp_pkg::ST_OFF;
      end
    endcase
    if (!active)
    begin
      d.st = clp_pkg::ST_OFF;
      d.cnt = 41'h0;
    end
    // Status pin multiplexer.
    case (q.pin_cfg[clp_pkg::POS_STAT_SEL +: 2])
      2'h0: d.stat_pin = foreground_done_flag;
      2'h1: d.stat_pin = cal_stopped_flag;
      2'h2: d.stat_pin = alarm_flag;
      default: d.stat_pin = 1'b0;
    endcase
    // Sticky events: a new event wins over a clear in the same cycle.
    ev = 3'h0;
    ev[clp_pkg::IRQ_FG] = foreground_done_flag & ~q.fg_prev;
    ev[clp_pkg::IRQ_STOP] = cal_stopped_flag & ~q.stop_prev;
    ev[clp_pkg::IRQ_WAKE] = d.cal_start;
    if (wr && wb_req.adr[1:0] == 2'h0 && idx == clp_pkg::IDX_IRQ_STAT)
    begin
      d.irq_stat = q.irq_stat & ~wdat[2:0];
    end
    d.irq_stat = d.irq_stat | ev;
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      q <= '{sync: 2'h0, pin_cfg: clp_pkg::RST_PIN_CFG,
             soft_trig: clp_pkg::RST_SOFT_TRIG, lp_cfg: clp_pkg::RST_LP_CFG,
             irq_stat: clp_pkg::RST_IRQ, irq_mask: clp_pkg::RST_IRQ,
             st: clp_pkg::ST_OFF, cnt: 41'h0, ack: 1'b0, rdat: 8'h00,
             fg_prev: 1'b0, stop_prev: 1'b0, stat_pin: 1'b0, cal_start: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs all come from the state register.
  assign wb_ack = q.ack;
  assign wb_dat_o = {24'h000000, q.rdat};
  assign status_output_pin = q.stat_pin;
  assign cal_start = q.cal_start;
  assign core_sleep = (q.st == clp_pkg::ST_SLEEP);
  assign irq = |(q.irq_stat & q.irq_mask);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_STAT_LOW: assert property (
    q.pin_cfg[2:1] == 2'h3 |=> !status_output_pin)
    else $error("status pin not low for select 3");
  AST_STAT_FG: assert property (
    q.pin_cfg[2:1] == 2'h0 |=> status_output_pin == $past(foreground_done_flag))
    else $error("status pin does not follow foreground done");
  AST_STAT_STOP: assert property (
    q.pin_cfg[2:1] == 2'h1 |=> status_output_pin == $past(cal_stopped_flag))
    else $error("status pin does not follow background stopped");
  AST_SW_TRIG: assert property (
    (q.st == clp_pkg::ST_SLEEP && trig_mode && active && !q.pin_cfg[0]
     && q.soft_trig[0]) ##1 active |-> q.st == clp_pkg::ST_SLEEP)
    else $error("pin woke core while software source selected");
  AST_HW_TRIG: assert property (
    (q.st == clp_pkg::ST_SLEEP && trig_mode && active && q.pin_cfg[0]
     && !q.sync[1]) ##1 active |-> q.st == clp_pkg::ST_WAKE)
    else $error("low pin trigger did not wake core");
  // The default disable would switch this check off exactly while it has something to look at.
  AST_SOFT_RST: assert property (@(posedge clk_sys) disable iff (1'b0)
    !rst_n |=> q.soft_trig == clp_pkg::RST_SOFT_TRIG && q.lp_cfg == clp_pkg::RST_LP_CFG)
    else $error("wrong reset value of trigger or low-power config");
  AST_SLEEP_END: assert property (
    (q.st == clp_pkg::ST_SLEEP && !trig_mode && q.cnt == 41'h0) ##1 active
    |-> q.st == clp_pkg::ST_WAKE && q.cnt == WAKE_CYC[wake_code] - 41'h1)
    else $error("autonomous sleep did not end into wake delay");
  AST_SLEEP_LOAD: assert property (
    (q.st == clp_pkg::ST_OFF && active) ##1 active
    |-> q.cnt == SLEEP_CYC[sleep_code] - 41'h1)
    else $error("sleep counter loaded with wrong length");
  AST_LP_OFF: assert property (
    !active |=> q.st == clp_pkg::ST_OFF && !core_sleep)
    else $error("sequencer running while low-power inactive");
  AST_SYNC: assert property (
    $past(rst_n, 2) && $past(rst_n) |-> q.sync[1] == $past(external_trigger_pin, 2))
    else $error("external trigger not delayed by two flops");
endmodule : clp_ctrl
`default_nettype wire

// file: rtl/clp_pkg.sv
package clp_pkg;
  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] IDX_PIN_CFG = 8'h6b;
  localparam logic [7:0] IDX_SOFT_TRIG = 8'h6c;
  localparam logic [7:0] IDX_LP_CFG = 8'h6e;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
  localparam logic [7:0] IDX_STATE = 8'h72;
  // Values after reset.
  localparam logic [7:0] RST_PIN_CFG = 8'h00;
  localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
  localparam logic [7:0] RST_LP_CFG = 8'h88;
  localparam logic [2:0] RST_IRQ = 3'h0;
  // Field positions.
  localparam int POS_TRIG_SRC = 0;
  localparam int POS_STAT_SEL = 1;
  localparam int POS_SOFT_TRIG = 0;
  localparam int POS_LOWPOWER_CAL_ENABLE = 0;
  localparam int POS_LOWPOWER_TRIGGER_MODE = 1;
  localparam int POS_WAKE = 3;
  localparam int POS_SLEEP = 5;
  // Interrupt bit positions.
  localparam int IRQ_FG = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_WAKE = 2;
  // Delays in sample clock periods; clk_sys is the sample clock.
  localparam int CNT_W = 41;
  localparam logic [40:0] SYS_PER_SAMPLE = 41'h1;
  localparam logic [40:0] SLEEP_PER_0 = 41'd1152;
  localparam logic [40:0] SLEEP_PER_1 = 41'd4194432;
  localparam logic [40:0] SLEEP_PER_2 = 41'd33554560;
  localparam logic [40:0] SLEEP_PER_3 = 41'd268435584;
  localparam logic [40:0] SLEEP_PER_4 = 41'd2147483776;
  localparam logic [40:0] SLEEP_PER_5 = 41'd137438953600;
  localparam logic [40:0] SLEEP_PER_6 = 41'd1099511627904;
  localparam logic [40:0] WAKE_PER_0 = 41'd1152;
  localparam logic [40:0] WAKE_PER_1 = 41'd33554560;
  localparam logic [40:0] WAKE_PER_2 = 41'd268435584;
  localparam logic [40:0] WAKE_PER_3 = 41'd2147483776;
  localparam logic [6:0][40:0] SLEEP_CYC = {
    SLEEP_PER_6 * SYS_PER_SAMPLE, SLEEP_PER_5 * SYS_PER_SAMPLE,
    SLEEP_PER_4 * SYS_PER_SAMPLE, SLEEP_PER_3 * SYS_PER_SAMPLE,
    SLEEP_PER_2 * SYS_PER_SAMPLE, SLEEP_PER_1 * SYS_PER_SAMPLE,
    SLEEP_PER_0 * SYS_PER_SAMPLE};
  localparam logic [3:0][40:0] WAKE_CYC = {
    WAKE_PER_3 * SYS_PER_SAMPLE, WAKE_PER_2 * SYS_PER_SAMPLE,
    WAKE_PER_1 * SYS_PER_SAMPLE, WAKE_PER_0 * SYS_PER_SAMPLE};

  typedef enum logic [2:0] {ST_OFF, ST_SLEEP, ST_WAKE, ST_CAL, ST_PARK} clp_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [9:0] adr;
    logic [31:0] dat;
  } clp_wb_req_s;

  typedef struct packed {
    logic [1:0] sync;
    logic [7:0] pin_cfg;
    logic [7:0] soft_trig;
    logic [7:0] lp_cfg;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    clp_state_e st;
    logic [40:0] cnt;
    logic ack;
    logic [7:0] rdat;
    logic fg_prev;
    logic stop_prev;
    logic stat_pin;
    logic cal_start;
  } clp_state_s;
endpackage : clp_pkg
